// [verilog/cfi_top.sv]
// Purpose: CAN interrupt flags and filter control group with match path
// Assumes: Classic Wishbone slave, one clock, inputs synchronous
// Notes:   Ack comes one cycle after the request appears
`timescale 1ns/1ps

module cfi_top #(
  parameter int FILTER_BASE = 20
) (
  input  wire logic                                      ref_clk,
  input  wire logic                                      resetn,
  // Wishbone slave
  input  wire logic                                      wb_cyc_i,
  input  wire logic                                      wb_stb_i,
  input  wire logic                                      wb_we_i,
  input  wire logic [cfi_pkg::CFI_AW-1:0]                wb_adr_i,
  input  wire logic [3:0]                                wb_sel_i,
  input  wire logic [31:0]                               wb_dat_i,
  output logic [31:0]                                    wb_dat_o,
  output logic                                           wb_ack_o,
  // Controller events and status
  input  wire logic                                      wake_event,
  input  wire logic                                      bus_error_event,
  input  wire logic                                      sys_error_event,
  input  wire logic                                      rx_pending,
  input  wire logic                                      tx_pending,
  input  wire logic [cfi_pkg::CFI_MODE_W-1:0]            current_op_mode,
  // Match path
  input  wire logic                                      msg_valid,
  input  wire logic [cfi_pkg::CFI_ID_W-1:0]              msg_id,
  input  wire logic [cfi_pkg::CFI_NMASK*cfi_pkg::CFI_ID_W-1:0] acc_masks,
  input  wire logic [cfi_pkg::CFI_NFLT*cfi_pkg::CFI_ID_W-1:0]  filt_idents,
  input  wire logic [cfi_pkg::CFI_NFIFO-1:0]             fifo_full,
  output logic                                           rx_store,
  output logic [cfi_pkg::CFI_FS_W-1:0]                   rx_fifo_num,
  output logic [4:0]                                     rx_filter_num,
  // Control out
  output logic                                           module_on,
  output logic [cfi_pkg::CFI_MODE_W-1:0]                 requested_op_mode
);

  import cfi_pkg::*;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic        ack_r;
  logic [31:0] rdat_r;
  logic [31:0] int_r;
  logic [31:0] ctrl_r;
  logic [31:0] flt_r;
  logic [CFI_TMR_W-1:0] tmr_r;
  logic [CFI_MODE_W-1:0] cur_prev_r;
  logic        on_prev_r;

  wire req      = wb_cyc_i && wb_stb_i;
  wire wr_take  = req && wb_we_i && ack_r;
  wire hit_int  = (wb_adr_i == CFI_OFS_INT);
  wire hit_ctrl = (wb_adr_i == CFI_OFS_CTRL);
  wire hit_flt  = (wb_adr_i == CFI_OFS_FLT);
  wire hit_tmr  = (wb_adr_i == CFI_OFS_TMR);

  wire wr_int   = wr_take && hit_int;
  wire wr_ctrl  = wr_take && hit_ctrl;
  wire wr_flt   = wr_take && hit_flt;
  wire wr_tmr   = wr_take && hit_tmr;

  // Byte-lane write mask
  wire [31:0] lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                           {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] wdat_m    = wb_dat_i & lane_mask;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  wire on_now   = ctrl_r[CFI_B_ON];
  wire on_rise  = on_now && !on_prev_r;
  wire [31:0] ctrl_wmask;
  wire [31:0] ctrl_nxt;

  assign ctrl_wmask = lane_mask &
                      ((32'h1 << CFI_B_ON) |
                       (32'h7 << CFI_REQ_LO));
  assign ctrl_nxt   = (ctrl_r & ~ctrl_wmask) | (wb_dat_i & ctrl_wmask);

  assign module_on         = on_now;
  assign requested_op_mode = ctrl_r[CFI_REQ_LO +: CFI_MODE_W];

  // ----------------------------------------------------------------
  // Filter control register
  // ----------------------------------------------------------------
  logic [31:0] flt_wmask;
  logic [31:0] flt_nxt;

  always_comb begin
    flt_wmask = lane_mask;
    for (int i = 0; i < CFI_NFLT; i++) begin
      if (flt_r[i*8 + CFI_F_EN]) begin
        flt_wmask[i*8 +: CFI_F_EN] = 7'h00;
      end
    end
    flt_nxt = (flt_r & ~flt_wmask) | (wb_dat_i & flt_wmask);
  end

  // ----------------------------------------------------------------
  // Filter compare
  // ----------------------------------------------------------------
  logic [CFI_NFLT-1:0] f_hit;

  genvar g;
  generate
    for (g = 0; g < CFI_NFLT; g++) begin : g_slot
      cfi_filter_slot #(
        .ID_W        (CFI_ID_W)
      ) u_slot (
        .filter_on   (flt_r[g*8 + CFI_F_EN]),
        .mask_choice (flt_r[g*8 + CFI_F_MS_LO +: CFI_MS_W]),
        .masks       (acc_masks),
        .ident       (filt_idents[g*CFI_ID_W +: CFI_ID_W]),
        .msg_id      (msg_id),
        .hit         (f_hit[g])
      );
    end
  endgenerate

  // Lowest numbered enabled filter that matches wins
  logic [1:0]          win_idx;
  logic                any_hit;

  always_comb begin
    win_idx = 2'h0;
    any_hit = 1'b0;
    for (int i = CFI_NFLT - 1; i >= 0; i--) begin
      if (f_hit[i]) begin
        win_idx = 2'(i);
        any_hit = 1'b1;
      end
    end
  end

  wire [CFI_FS_W-1:0] win_fifo = flt_r[win_idx*8 + CFI_F_FS_LO +: CFI_FS_W];
  wire match_go  = on_now && msg_valid && any_hit;
  wire full_tgt  = fifo_full[win_fifo];
  wire store_go  = match_go && !full_tgt;
  wire ovfl_go   = match_go && full_tgt;

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  wire [CFI_MODE_W-1:0] req_mode = ctrl_r[CFI_REQ_LO +: CFI_MODE_W];
  wire mode_go  = (current_op_mode == req_mode) &&
                  (cur_prev_r != current_op_mode);
  wire tmr_max  = (tmr_r == {CFI_TMR_W{1'b1}});
  wire wrap_go  = on_now && tmr_max;
  wire [CFI_TMR_W-1:0] tmr_inc = tmr_r + 1'b1;

  // ----------------------------------------------------------------
  // Flag register next value
  // ----------------------------------------------------------------
  logic [31:0] int_set;
  logic [31:0] int_clr;
  logic [31:0] int_nxt;

  always_comb begin
    int_set = 32'h0;
    int_set[CFI_B_WAKE]  = wake_event;
    int_set[CFI_B_BERR]  = bus_error_event;
    int_set[CFI_B_SERR]  = sys_error_event;
    int_set[CFI_B_RXOV]  = ovfl_go;
    int_set[CFI_B_MODE]  = mode_go;
    int_set[CFI_B_TWRAP] = wrap_go;
    int_clr = 32'h0;
    if (wr_int) begin
      int_clr = wdat_m;
    end
    int_clr[CFI_B_SERR] = on_rise;
    int_nxt = (int_r & ~int_clr) | int_set;
    int_nxt[CFI_B_RXP] = rx_pending;
    int_nxt[CFI_B_TXP] = tx_pending;
    int_nxt[10:4]      = 7'h00;
    int_nxt[31:15]     = 17'h0;
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [31:0] ctrl_rd;
  logic [31:0] rd_mux;

  always_comb begin
    ctrl_rd = ctrl_r;
    ctrl_rd[CFI_CUR_LO +: CFI_MODE_W] = current_op_mode;
    rd_mux = 32'h0;
    if (hit_int) begin
      rd_mux = int_r;
    end else if (hit_ctrl) begin
      rd_mux = ctrl_rd;
    end else if (hit_flt) begin
      rd_mux = flt_r;
    end else if (hit_tmr) begin
      rd_mux = {{(32-CFI_TMR_W){1'b0}}, tmr_r};
    end
  end

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0;
    end else begin
      ack_r  <= req && !ack_r;
      rdat_r <= rd_mux;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r    <= {5'h0, CFI_REQ_RST, 24'h0};
      on_prev_r <= 1'b0;
    end else begin
      on_prev_r <= on_now;
      if (wr_ctrl) begin
        ctrl_r <= ctrl_nxt;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      flt_r <= CFI_FLT_RST;
    end else if (wr_flt) begin
      flt_r <= flt_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      int_r <= CFI_INT_RST;
    end else begin
      int_r <= int_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cur_prev_r <= '0;
    end else begin
      cur_prev_r <= current_op_mode;
    end
  end

  // Module timer runs while enabled; software may preload it
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tmr_r <= '0;
    end else if (wr_tmr) begin
      tmr_r <= wdat_m[CFI_TMR_W-1:0];
    end else if (on_now) begin
      tmr_r <= tmr_inc;
    end
  end

  // ----------------------------------------------------------------
  // Match outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_store      <= 1'b0;
      rx_fifo_num   <= '0;
      rx_filter_num <= '0;
    end else begin
      rx_store <= store_go;
      if (match_go) begin
        rx_fifo_num   <= win_fifo;
        rx_filter_num <= 5'(FILTER_BASE + int'(win_idx));
      end
    end
  end

endmodule // cfi_top

// [verilog/cfi_pkg.sv]
// Purpose: Shared constants for the CAN filter control and flag block
// Assumes: Classic Wishbone, 32-bit data, word-aligned registers
// Notes:   Offsets are byte addresses

package cfi_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] CFI_OFS_INT   = 4'h0;
  localparam logic [3:0] CFI_OFS_CTRL  = 4'h4;
  localparam logic [3:0] CFI_OFS_FLT   = 4'h8;
  localparam logic [3:0] CFI_OFS_TMR   = 4'hc;
  localparam int         CFI_AW        = 4;

  // ----------------------------------------------------------------
  // Flag bit positions
  // ----------------------------------------------------------------
  localparam int CFI_B_WAKE   = 14;
  localparam int CFI_B_BERR   = 13;
  localparam int CFI_B_SERR   = 12;
  localparam int CFI_B_RXOV   = 11;
  localparam int CFI_B_MODE   = 3;
  localparam int CFI_B_TWRAP  = 2;
  localparam int CFI_B_RXP    = 1;
  localparam int CFI_B_TXP    = 0;
  localparam logic [31:0] CFI_INT_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CFI_B_ON     = 15;
  localparam int CFI_REQ_LO   = 24;
  localparam int CFI_CUR_LO   = 21;
  localparam int CFI_MODE_W   = 3;
  localparam logic [2:0] CFI_REQ_RST = 3'h4;

  // ----------------------------------------------------------------
  // Filter byte layout
  // ----------------------------------------------------------------
  localparam int CFI_NFLT     = 4;
  localparam int CFI_F_EN     = 7;
  localparam int CFI_F_MS_LO  = 5;
  localparam int CFI_F_FS_LO  = 0;
  localparam int CFI_MS_W     = 2;
  localparam int CFI_FS_W     = 5;
  localparam int CFI_NMASK    = 4;
  localparam int CFI_NFIFO    = 32;
  localparam int CFI_ID_W     = 29;
  localparam logic [31:0] CFI_FLT_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Module timer
  // ----------------------------------------------------------------
  localparam int CFI_TMR_W = 16;

endpackage

// [verilog/cfi_filter_slot.sv]
// Purpose: One acceptance filter compare
// Assumes: Mask bit 1 means the identifier bit must match
// Notes:   Purely combinational
`timescale 1ns/1ps

module cfi_filter_slot #(
  parameter int ID_W = 29
) (
  input  wire logic                 filter_on,
  input  wire logic [1:0]           mask_choice,
  input  wire logic [4*ID_W-1:0]    masks,
  input  wire logic [ID_W-1:0]      ident,
  input  wire logic [ID_W-1:0]      msg_id,
  output logic                      hit
);

  // ----------------------------------------------------------------
  // Compare
  // ----------------------------------------------------------------
  wire [ID_W-1:0] sel_mask;
  wire [ID_W-1:0] diff;

  assign sel_mask = masks[mask_choice*ID_W +: ID_W];
  assign diff     = (msg_id ^ ident) & sel_mask;
  assign hit      = filter_on && (diff == '0);

endmodule // cfi_filter_slot

// [dv/cfi_top_props.sv]
// Purpose: Port checker for cfi_top
// Assumes: Ack one cycle after request
// Notes:   Attached by bind
`timescale 1ns/1ps

module cfi_top_props
  import cfi_pkg::*;
#(
  parameter int FILTER_BASE = 20
) (
  input wire logic                 ref_clk,
  input wire logic                 resetn,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_we_i,
  input wire logic [CFI_AW-1:0]    wb_adr_i,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 wb_ack_o,
  input wire logic                 rx_pending,
  input wire logic                 tx_pending,
  input wire logic                 msg_valid,
  input wire logic                 module_on,
  input wire logic [CFI_NFIFO-1:0] fifo_full,
  input wire logic                 rx_store,
  input wire logic [CFI_FS_W-1:0]  rx_fifo_num,
  input wire logic [4:0]           rx_filter_num
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic rd_req;
  assign rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("ack missing");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_unmap_zero: assert property (rd_req && wb_adr_i[1:0] != 2'b00
    |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_resv_zero: assert property (rd_req && wb_adr_i == CFI_OFS_INT
    |=> wb_dat_o[10:4] == 7'h0) else $error("reserved flags set");
  a_pend_follow: assert property (rd_req && wb_adr_i == CFI_OFS_INT
    && $past(resetn) |=> wb_dat_o[1:0] ==
    {$past(rx_pending, 2), $past(tx_pending, 2)})
    else $error("pending flags wrong");
  a_store_cause: assert property (rx_store
    |-> $past(msg_valid) && $past(module_on)) else $error("store no cause");
  a_store_room: assert property (rx_store
    |-> !(|($past(fifo_full) & (32'h1 << rx_fifo_num))))
    else $error("store into full fifo");
  a_full_drops: assert property (msg_valid && fifo_full == '1
    |=> !rx_store) else $error("store while all full");
  a_filter_num: assert property (rx_store
    |-> rx_filter_num >= 5'(FILTER_BASE) && rx_filter_num < 5'(FILTER_BASE + 4))
    else $error("filter number out of range");
  c_store: cover property (rx_store);
  c_int_read: cover property (rd_req && wb_adr_i == CFI_OFS_INT);
  c_full: cover property (msg_valid && fifo_full != '0);
endmodule // cfi_top_props

bind cfi_top cfi_top_props #(.FILTER_BASE(FILTER_BASE)) u_props (
  .ref_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
  .wb_ack_o, .rx_pending, .tx_pending, .msg_valid, .module_on, .fifo_full,
  .rx_store, .rx_fifo_num, .rx_filter_num);

// [dv/cfi_can_peer.sv]
// Purpose: Other CAN nodes feeding messages and bus events
// Assumes: Commands come from the bench one cycle ahead
// Notes:   Identifier toggles while no message is valid
`timescale 1ns/1ps

module cfi_can_peer (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        send,
  input  wire logic        err,
  input  wire logic        wake,
  input  wire logic [28:0] id,
  output logic             msg_valid,
  output logic [28:0]      msg_id,
  output logic             bus_error_event,
  output logic             wake_event
);
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      msg_valid       <= 1'b0;
      msg_id          <= '0;
      bus_error_event <= 1'b0;
      wake_event      <= 1'b0;
    end else begin
      msg_valid       <= send;
      msg_id          <= send ? id : ~msg_id;
      bus_error_event <= err;
      wake_event      <= wake;
    end
  end
endmodule // cfi_can_peer

// [dv/testbench.sv]
// Purpose: Self-checking bench for cfi_top
// Assumes: Ack returns within 50 cycles
// Notes:   Reads and stores are compared from queues
`timescale 1ns/1ps

module testbench;
  import cfi_pkg::*;
  logic         ref_clk, resetn, cyc, stb, we, sys_err, rxp, txp;
  logic         send, err, wake, mv, bev, wev, ack, store;
  logic [3:0]   adr, sel;
  logic [31:0]  dat, dout, full, w1;
  logic [2:0]   cur;
  logic [28:0]  id, mid;
  logic [115:0] masks, idents;
  logic [4:0]   fnum, fltn, f;
  logic         mon;
  logic [2:0]   rqm;
  logic [31:0]  q_rd[$], q_rx[$];
  int           n_fail, checks, cyc_n;

  cfi_top uut (.ref_clk, .resetn, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dout), .wb_ack_o(ack), .wake_event(wev),
    .bus_error_event(bev), .sys_error_event(sys_err), .rx_pending(rxp),
    .tx_pending(txp), .current_op_mode(cur), .msg_valid(mv), .msg_id(mid),
    .acc_masks(masks), .filt_idents(idents), .fifo_full(full),
    .rx_store(store), .rx_fifo_num(fnum), .rx_filter_num(fltn),
    .module_on(mon), .requested_op_mode(rqm));
  cfi_can_peer peer (.ref_clk, .resetn, .send, .err, .wake, .id,
    .msg_valid(mv), .msg_id(mid), .bus_error_event(bev), .wake_event(wev));

  task automatic chk(input string nm, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    q_rd.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic msg(input logic [28:0] i);
    send <= 1'b1;
    id <= i;
    @(posedge ref_clk);
    send <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  // ----------------------------------------------------------------
  // Monitor and timeout
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (ack && !we) chk("read", dout, q_rd.size() ? q_rd.pop_front() : 'x);
    if (store) chk("store", {22'h0, fnum, fltn}, q_rx.size() ? q_rx.pop_front() : 'x);
    cyc_n++;
    if (cyc_n == 5000) begin
      n_fail++;
      report_and_stop;
    end
  end
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {resetn, cyc, stb, we, sys_err, rxp, txp, send, err, wake} = '0;
    {adr, dat, full, cur, id, masks} = '0;
    sel = 4'hf;
    void'($urandom(32'h581518d1));
    idents = 116'({$urandom, $urandom, $urandom, $urandom});
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    rd(CFI_OFS_INT, CFI_INT_RST);
    rd(CFI_OFS_FLT, CFI_FLT_RST);
    rd(CFI_OFS_CTRL, 32'h0400_0000);
    rd(4'h2, 32'h0);
    chk("req mode", {29'h0, rqm}, 32'h4);
    $display("test reset done");
    w1 = $urandom & 32'h7f7f_7f7f;
    wb(1'b1, CFI_OFS_FLT, w1);
    rd(CFI_OFS_FLT, w1);
    wb(1'b1, CFI_OFS_FLT, ~w1);
    rd(CFI_OFS_FLT, ~w1);
    wb(1'b1, CFI_OFS_FLT, w1);
    rd(CFI_OFS_FLT, ~w1 & 32'h7f7f_7f7f);
    sel <= 4'h1;
    wb(1'b1, CFI_OFS_FLT, 32'hffff_ffff);
    sel <= 4'hf;
    rd(CFI_OFS_FLT, (~w1 & 32'h7f7f_7f00) | 32'hff);
    $display("test field lock done");
    wb(1'b1, CFI_OFS_CTRL, 32'h0400_8000);
    chk("module on", {31'h0, mon}, 32'h1);
    for (int m = 0; m < 4; m++) begin
      f = 5'($urandom);
      wb(1'b1, CFI_OFS_FLT, 32'h0);
      wb(1'b1, CFI_OFS_FLT, {24'h0, 1'b1, 2'(m), f});
      masks <= 116'({29{1'b1}}) << (m * 29);
      msg(idents[28:0] ^ 29'h1);
      q_rx.push_back({22'h0, f, 5'd20});
      msg(idents[28:0]);
    end
    masks <= '0;
    wb(1'b1, CFI_OFS_FLT, 32'h0);
    wb(1'b1, CFI_OFS_FLT, 32'h009f_0000);
    q_rx.push_back({22'h0, 5'd31, 5'd22});
    msg(29'($urandom));
    full <= '1;
    msg(29'($urandom));
    full <= '0;
    $display("test match done");
    {rxp, txp, sys_err, err, wake} <= '1;
    cur <= 3'h4;
    @(posedge ref_clk);
    {sys_err, err, wake} <= '0;
    wb(1'b1, CFI_OFS_TMR, 32'h0000_fffe);
    repeat (4) @(posedge ref_clk);
    rd(CFI_OFS_INT, 32'h0000_780f);
    wb(1'b1, CFI_OFS_INT, 32'hffff_ffff);
    rd(CFI_OFS_INT, 32'h0000_1003);
    {rxp, txp} <= '0;
    wb(1'b1, CFI_OFS_CTRL, 32'h0400_0000);
    chk("module off", {31'h0, mon}, 32'h0);
    wb(1'b1, CFI_OFS_CTRL, 32'h0400_8000);
    rd(CFI_OFS_INT, 32'h0);
    $display("test flags done");
    report_and_stop;
  end
endmodule // testbench
